/* tb/sebl_eeprom.sv */
// Serial EEPROM model holding the boot image
`timescale 1ns/1ps
module sebl_eeprom (
  input wire select_n,
  input wire sk,
  input wire si,
  output reg so = 1'b0,
  output reg hdr_bad = 1'b0
);
  localparam [14:0] HDR = 15'h6000;
  reg [7:0] mem [0:4095];
  integer rises = 0;
  integer b;
  // Rising edges count the frame and check the read header; deselect restarts it
  always @(posedge sk or posedge select_n) begin
    if (select_n) begin
      rises = 0;
    end else begin
      rises = rises + 1;
      if (rises <= 15 && si !== HDR[15 - rises]) hdr_bad <= 1'b1;
    end
  end
  // Data moves on the falling edge; a released line shows the inverse of its last value
  always @(negedge sk or posedge select_n) begin
    b = rises - 16;
    if (!select_n && rises >= 16) so <= mem[b / 8][7 - b % 8];
    else so <= ~so;
  end
endmodule // sebl_eeprom

/* tb/sebl_loader_monitor.sv */
// Port assertions for the boot image loader
`timescale 1ns/1ps
module sebl_mon (
  input wire sys_clk,
  input wire rst_n,
  input wire eeprom_select_n,
  input wire eeprom_serial_clock,
  input wire eeprom_serial_in,
  input wire load_done,
  input wire system_reset_n,
  input wire crc_status_out,
  input wire program_ram_we,
  input wire [9:0] program_ram_addr,
  input wire coefficient_ram_we,
  input wire [9:0] coefficient_ram_addr,
  input wire offset_ram_we,
  input wire [5:0] offset_ram_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Write spacing is bytes per unit times 64 cycles per byte
  property p_park; load_done |-> eeprom_select_n && !eeprom_serial_clock && !eeprom_serial_in;
  endproperty
  a_park: assert property (p_park) else $error("pins not parked");
  property p_hold; !eeprom_select_n |-> !system_reset_n && !load_done; endproperty
  a_hold: assert property (p_hold) else $error("reset not held");
  property p_rel; $rose(load_done) |-> system_reset_n; endproperty
  a_rel: assert property (p_rel) else $error("reset not released");
  property p_stick; load_done |=> load_done; endproperty
  a_stick: assert property (p_stick) else $error("done dropped");
  property p_skhi; $rose(eeprom_serial_clock) |-> eeprom_serial_clock [*4] ##1 !eeprom_serial_clock;
  endproperty
  a_skhi: assert property (p_skhi) else $error("clock high phase wrong");
  property p_pgap; program_ram_we && program_ram_addr != 10'h2FF |-> ##256 program_ram_we;
  endproperty
  a_pgap: assert property (p_pgap) else $error("program write spacing");
  property p_cgap; coefficient_ram_we && coefficient_ram_addr != 10'h1AA |-> ##128 coefficient_ram_we;
  endproperty
  a_cgap: assert property (p_cgap) else $error("coefficient write spacing");
  property p_ogap; offset_ram_we && offset_ram_addr != 6'h2F |-> ##192 offset_ram_we; endproperty
  a_ogap: assert property (p_ogap) else $error("offset write spacing");
  property p_pmax; program_ram_we |-> program_ram_addr <= 10'h2FF; endproperty
  a_pmax: assert property (p_pmax) else $error("program address high");
  property p_crc; crc_status_out |-> load_done; endproperty
  a_crc: assert property (p_crc) else $error("check status before done");
  c_done: cover property ($rose(load_done));
  c_ofs: cover property (offset_ram_we && offset_ram_addr == 6'h2F);
  c_crc: cover property (crc_status_out);
endmodule // sebl_mon
bind sebl_loader sebl_mon u_mon (.*);

/* tb/sebl_loader_test.sv */
// Self-checking bench for the boot image loader
`timescale 1ns/1ps
module sebl_loader_test;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg boot_select = 1'b0;
  wire sel_n, sk, si, so, hdr_bad, done, srst_n, crc_ok, img_err, p_we, c_we, o_we;
  wire [9:0] p_a, c_a;
  wire [5:0] o_a;
  wire [31:0] p_d;
  wire [15:0] c_d;
  wire [23:0] o_d;
  wire [7:0] k0, k1, k2, k3, k4, k5;
  integer fails = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer i;
  reg [15:0] crc;
  sebl_loader dut (.sys_clk(sys_clk), .rst_n(rst_n), .boot_select(boot_select),
    .eeprom_serial_out(so), .eeprom_select_n(sel_n), .eeprom_serial_clock(sk),
    .eeprom_serial_in(si), .load_done(done), .system_reset_n(srst_n),
    .crc_status_out(crc_ok), .image_error(img_err), .program_ram_we(p_we),
    .program_ram_addr(p_a), .program_ram_data(p_d), .coefficient_ram_we(c_we),
    .coefficient_ram_addr(c_a), .coefficient_ram_data(c_d), .offset_ram_we(o_we),
    .offset_ram_addr(o_a), .offset_ram_data(o_d), .control_reg_0(k0), .control_reg_1(k1),
    .control_reg_2(k2), .control_reg_3(k3), .control_reg_4(k4), .control_reg_5(k5));
  sebl_eeprom eep (.select_n(sel_n), .sk(sk), .si(si), .so(so), .hdr_bad(hdr_bad));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Image byte: fixed codes where the map demands them, an address pattern elsewhere
  function [7:0] img(input [11:0] a);
    begin
      img = a[7:0] ^ a[11:4];
      if (a == 12'h000) img = 8'hC0;
      if (a == 12'hC03) img = 8'hA0;
      if (a == 12'hF5C) img = 8'h90;
      if (a == 12'hFFC) img = 8'hB6;
      if (a >= 12'hFEE && a <= 12'hFF8 && !a[0]) img = a[7:0] - 8'h8E;
      if (a == 12'h1 || a == 12'h2 || a == 12'hC04 || a == 12'hC05) img = 8'h00;
      if (a == 12'hF5D || a == 12'hFFA || a == 12'hFFB || a == 12'hFFF) img = 8'h00;
    end
  endfunction
  task check(input [47:0] seen, input [47:0] want);
    begin
      total_checks = total_checks + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("mismatch t=%0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task do_reset(input bsel);
    begin
      @(posedge sys_clk);
      #10;
      rst_n = 1'b0;
      boot_select = bsel;
      repeat (10) @(posedge sys_clk);
      #10;
      rst_n = 1'b1;
    end
  endtask
  // Boot select low: no frame, reset released, done stays low
  task t_no_boot;
    begin
      do_reset(1'b0);
      repeat (40) @(posedge sys_clk);
      #10;
      check({srst_n, done, sel_n, sk, crc_ok}, 5'h14);
    end
  endtask
  // Loading is under way and holds the system in reset; a reset then aborts it
  task t_abort;
    begin
      do_reset(1'b1);
      repeat (3000) @(posedge sys_clk);
      #10;
      check({sel_n, srst_n, done, crc_ok}, 4'h0);
    end
  endtask
  task t_full;
    integer np, nc, no;
    reg [11:0] b;
    begin
      np = 0;
      nc = 0;
      no = 0;
      do_reset(1'b1);
      while (done !== 1'b1) begin
        @(posedge sys_clk);
        #10;
        b = 12'h003 + {np[9:0], 2'h0};
        if (p_we === 1'b1) check({p_a, p_d}, {np[9:0], img(b), img(b + 1), img(b + 2), img(b + 3)});
        if (p_we === 1'b1) np = np + 1;
        b = 12'hC06 + {nc[10:0], 1'h0};
        if (c_we === 1'b1) check({c_a, c_d}, {nc[9:0], img(b), img(b + 1)});
        if (c_we === 1'b1) nc = nc + 1;
        b = 12'hF5E + {no[10:0], 1'h0} + no[11:0];
        if (o_we === 1'b1) check({o_a, o_d}, {no[5:0], img(b), img(b + 1), img(b + 2)});
        if (o_we === 1'b1) no = no + 1;
      end
      @(posedge sys_clk);
      #10;
      check({np[15:0], nc[15:0], no[15:0]}, {16'h0300, 16'h01AB, 16'h0030});
      check({k0, k1, k2, k3, k4, k5}, {img(12'hFEF), img(12'hFF1), img(12'hFF3),
        img(12'hFF5), img(12'hFF7), img(12'hFF9)});
      check({crc_ok, srst_n, sel_n, sk, si}, 5'h1C);
      check({img_err, hdr_bad}, 2'h0);
    end
  endtask
  task end_of_test;
    begin
      if (fails == 0 && total_checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  // Hang guard sized to one full image read plus margin
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 290000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  initial begin
    crc = 16'h0000;
    for (i = 0; i < 4096; i = i + 1) eep.mem[i] = img(i[11:0]);
    // Remainder of the data shifted by 16, MSB first, over bytes 0000h..0FFBh
    for (i = 0; i < 32736; i = i + 1)
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ eep.mem[i[14:3]][~i[2:0]]) ? 16'h1021 : 16'h0);
    eep.mem[12'hFFD] = crc[15:8];
    eep.mem[12'hFFE] = crc[7:0];
    t_no_boot;
    t_abort;
    t_full;
    end_of_test;
  end
endmodule // sebl_loader_test

/* verilog/sebl_defs.vh */
// Constants for the serial EEPROM boot image loader
`ifndef SEBL_DEFS_VH
`define SEBL_DEFS_VH

// Link timing: EEPROM clock period and system clock period in ns
`define SEBL_CLK_PERIOD_NS 100
`define SEBL_SK_PERIOD_NS 800
`define SEBL_SK_DIV (`SEBL_SK_PERIOD_NS / `SEBL_CLK_PERIOD_NS)
// Divider phases: last count, sample point (just before rise), rise point
`define SEBL_DIV_LAST 3'h7
`define SEBL_DIV_SAMPLE 3'h3
`define SEBL_DIV_RISE 3'h4

// Serial read header: start bit, read opcode, 12-bit byte address zero
`define SEBL_RD_HDR 15'h6000
`define SEBL_RD_HDR_BITS 4'hF

// Image map byte addresses
`define SEBL_A_PCMD 12'h000
`define SEBL_A_PADH 12'h001
`define SEBL_A_PADL 12'h002
`define SEBL_A_PFIRST 12'h003
`define SEBL_A_PLAST 12'hC02
`define SEBL_A_CCMD 12'hC03
`define SEBL_A_CADH 12'hC04
`define SEBL_A_CADL 12'hC05
`define SEBL_A_CFIRST 12'hC06
`define SEBL_A_CLAST 12'hF5B
`define SEBL_A_OCMD 12'hF5C
`define SEBL_A_OADR 12'hF5D
`define SEBL_A_OFIRST 12'hF5E
`define SEBL_A_OLAST 12'hFED
`define SEBL_A_KFIRST 12'hFEE
`define SEBL_A_KLAST 12'hFF9
`define SEBL_A_CRCCMD 12'hFFC
`define SEBL_A_CRCH 12'hFFD
`define SEBL_A_CRCL 12'hFFE
`define SEBL_A_END 12'hFFF

// Command codes
`define SEBL_CMD_PROG 8'hC0
`define SEBL_CMD_COEF 8'hA0
`define SEBL_CMD_OFS 8'h90
`define SEBL_CMD_CTL0 8'h60
`define SEBL_CMD_CRC 8'hB6

// Word phases and counts
`define SEBL_PWORD_LAST 2'h2
`define SEBL_OFS_LAST 2'h2
`define SEBL_CTL_COUNT 3'h6

// CRC generator 11021h, low 16 bits
`define SEBL_CRC_POLY 16'h1021

`endif

/* verilog/sebl_loader.v */
// Serial EEPROM boot image loader: reads the 4 KB image and fills DSP memories
// Overview of operation
// - Image opens at byte 0 with C0h and two zero address bytes.
// - Program words are four bytes, MSB first, word 0 at 0003h, rising.
// - Program words 0 to 767, last byte at 0C02h.
// - Byte 0C03h holds A0h then two zero address bytes.
// - Coefficients are two bytes high first from 0C06h, 0 to 426, end 0F5Bh.
// - Byte 0F5Ch holds 90h, then zero address byte at 0F5Dh.
// - Offset entries are three bytes MSB first from 0F5Eh, 0 to 47.
// - Six command/data pairs from 0FEEh, codes 60h..6Ah, load control regs 0..5.
// - Byte 0FFCh holds B6h, then expected CRC high byte first.
// - After reset with boot select high drive select, clock, data; park when done.
// - Load-done rises when all data read; with boot select high, system reset held until then.
// - After load, CRC status output high if computed CRC matches stored value.
// - System reset released automatically when loading completes.
`timescale 1ns/1ps
`include "sebl_defs.vh"

module sebl_loader (
  input wire sys_clk,
  input wire rst_n,
  input wire boot_select,
  input wire eeprom_serial_out,
  output reg eeprom_select_n,
  output reg eeprom_serial_clock,
  output reg eeprom_serial_in,
  output reg load_done,
  output reg system_reset_n,
  output reg crc_status_out,
  output reg image_error,
  output reg program_ram_we,
  output reg [9:0] program_ram_addr,
  output reg [31:0] program_ram_data,
  output reg coefficient_ram_we,
  output reg [9:0] coefficient_ram_addr,
  output reg [15:0] coefficient_ram_data,
  output reg offset_ram_we,
  output reg [5:0] offset_ram_addr,
  output reg [23:0] offset_ram_data,
  output reg [7:0] control_reg_0,
  output reg [7:0] control_reg_1,
  output reg [7:0] control_reg_2,
  output reg [7:0] control_reg_3,
  output reg [7:0] control_reg_4,
  output reg [7:0] control_reg_5
);

  localparam ST_IDLE = 4'h1;
  localparam ST_HDR = 4'h2;
  localparam ST_DATA = 4'h4;
  localparam ST_DONE = 4'h8;
  // One CRC step per serial bit, MSB first
  function [15:0] sebl_crc_step;
    input [15:0] crc;
    input bit_in;
    sebl_crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ bit_in) ? `SEBL_CRC_POLY : 16'h0000);
  endfunction
  // True when a byte address lies in a closed range
  function in_range;
    input [11:0] a;
    input [11:0] lo;
    input [11:0] hi;
    in_range = (a >= lo) && (a <= hi);
  endfunction

  reg [3:0] state_q;
  reg [2:0] div_q;
  reg [1:0] bsel_sync_q;
  reg [1:0] so_sync_q;
  reg [14:0] hdr_q;
  reg [3:0] hdr_cnt_q;
  reg skip_q;
  reg [2:0] bit_cnt_q;
  reg [7:0] byte_sh_q;
  reg [11:0] byte_addr_q;
  reg [31:0] asm_q;
  reg [1:0] ofs_ph_q;
  reg [2:0] ctl_idx_q;
  reg [15:0] crc_q;
  reg [15:0] crc_exp_q;
  reg ctl_we;
  wire bsel_s = bsel_sync_q[1];
  wire so_s = so_sync_q[1];
  wire sample = (div_q == `SEBL_DIV_SAMPLE);
  wire fall = (div_q == `SEBL_DIV_LAST);
  wire byte_ready = (state_q == ST_DATA) && sample && !skip_q && (bit_cnt_q == 3'h7);
  wire [7:0] new_byte = {byte_sh_q[6:0], so_s}; // Latest bit in the low end
  wire last_byte = byte_ready && (byte_addr_q == `SEBL_A_END); // No clock rise as select lifts

  // Boot select and EEPROM data pins pass two flops before any logic sees them
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      bsel_sync_q <= 2'h0;
      so_sync_q <= 2'h0;
    end else begin
      bsel_sync_q <= {bsel_sync_q[0], boot_select};
      so_sync_q <= {so_sync_q[0], eeprom_serial_out};
    end
  end

  // Free-running divider; the EEPROM clock only toggles while selected
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      div_q <= 3'h0;
      eeprom_serial_clock <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      if ((state_q == ST_HDR || state_q == ST_DATA) && !last_byte)
        eeprom_serial_clock <= (div_q + 3'h1) >= `SEBL_DIV_RISE;
      else
        eeprom_serial_clock <= 1'b0;
    end
  end

  // Sequencer: idle, send read header, stream 4096 bytes, park
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      eeprom_select_n <= 1'b1;
      eeprom_serial_in <= 1'b0;
      hdr_q <= `SEBL_RD_HDR;
      hdr_cnt_q <= 4'h0;
      skip_q <= 1'b1;
      bit_cnt_q <= 3'h0;
      byte_sh_q <= 8'h00;
      byte_addr_q <= 12'h000;
      load_done <= 1'b0;
      system_reset_n <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // Wait one divider lap so the boot select synchroniser has settled
          if (fall) begin
            if (bsel_s) begin
              state_q <= ST_HDR;
              eeprom_select_n <= 1'b0;
              eeprom_serial_in <= hdr_q[14];
              hdr_q <= {hdr_q[13:0], 1'b0};
            end else begin
              state_q <= ST_DONE;
              system_reset_n <= 1'b1;
            end
          end
        end
        ST_HDR: begin
          if (sample)
            hdr_cnt_q <= hdr_cnt_q + 4'h1;
          if (fall) begin
            if (hdr_cnt_q == `SEBL_RD_HDR_BITS) begin
              state_q <= ST_DATA;
              eeprom_serial_in <= 1'b0;
            end else begin
              eeprom_serial_in <= hdr_q[14];
              hdr_q <= {hdr_q[13:0], 1'b0};
            end
          end
        end
        ST_DATA: begin
          // First sample after the header is the EEPROM's dummy zero
          if (sample) begin
            if (skip_q) begin
              skip_q <= 1'b0;
            end else begin
              byte_sh_q <= new_byte;
              bit_cnt_q <= bit_cnt_q + 3'h1;
            end
          end
          if (byte_ready) begin
            byte_addr_q <= byte_addr_q + 12'h001;
            if (byte_addr_q == `SEBL_A_END) begin
              state_q <= ST_DONE;
              eeprom_select_n <= 1'b1;
              eeprom_serial_in <= 1'b0;
              load_done <= 1'b1;
              system_reset_n <= 1'b1;
            end
          end
        end
        ST_DONE: begin
          eeprom_select_n <= 1'b1;
          eeprom_serial_in <= 1'b0;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // CRC over bytes 0000h..0FFBh, computed bit by bit as they arrive
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      crc_q <= 16'h0000;
      crc_exp_q <= 16'h0000;
      crc_status_out <= 1'b0;
    end else begin
      if (state_q == ST_DATA && sample && !skip_q && byte_addr_q < `SEBL_A_CRCCMD)
        crc_q <= sebl_crc_step(crc_q, so_s);
      if (byte_ready && byte_addr_q == `SEBL_A_CRCH)
        crc_exp_q[15:8] <= new_byte;
      if (byte_ready && byte_addr_q == `SEBL_A_CRCL)
        crc_exp_q[7:0] <= new_byte;
      // Output only valid once loading finished; low in bypass as nothing was checked
      crc_status_out <= load_done && (crc_q == crc_exp_q);
    end
  end

  // Section dispatch: assemble words and write memories, check fixed bytes
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      asm_q <= 32'h00000000;
      ofs_ph_q <= 2'h0;
      ctl_idx_q <= 3'h0;
      ctl_we <= 1'b0;
      image_error <= 1'b0;
      program_ram_we <= 1'b0;
      program_ram_addr <= 10'h3FF;
      program_ram_data <= 32'h00000000;
      coefficient_ram_we <= 1'b0;
      coefficient_ram_addr <= 10'h3FF;
      coefficient_ram_data <= 16'h0000;
      offset_ram_we <= 1'b0;
      offset_ram_addr <= 6'h3F;
      offset_ram_data <= 24'h000000;
    end else begin
      program_ram_we <= 1'b0;
      coefficient_ram_we <= 1'b0;
      offset_ram_we <= 1'b0;
      ctl_we <= 1'b0;
      if (byte_ready) begin
        asm_q <= {asm_q[23:0], new_byte};
        // Fixed command and zero address bytes; a mismatch is flagged, not fatal
        if ((byte_addr_q == `SEBL_A_PCMD && new_byte != `SEBL_CMD_PROG) ||
            (byte_addr_q == `SEBL_A_CCMD && new_byte != `SEBL_CMD_COEF) ||
            (byte_addr_q == `SEBL_A_OCMD && new_byte != `SEBL_CMD_OFS) ||
            (byte_addr_q == `SEBL_A_CRCCMD && new_byte != `SEBL_CMD_CRC) ||
            ((in_range(byte_addr_q, `SEBL_A_PADH, `SEBL_A_PADL) ||
              in_range(byte_addr_q, `SEBL_A_CADH, `SEBL_A_CADL) ||
              byte_addr_q == `SEBL_A_OADR) && new_byte != 8'h00))
          image_error <= 1'b1;
        if (in_range(byte_addr_q, `SEBL_A_KFIRST, `SEBL_A_KLAST) && !byte_addr_q[0] &&
            new_byte != (`SEBL_CMD_CTL0 + {4'h0, ctl_idx_q, 1'b0}))
          image_error <= 1'b1;
        // Program word completes on its fourth byte
        if (in_range(byte_addr_q, `SEBL_A_PFIRST, `SEBL_A_PLAST) &&
            byte_addr_q[1:0] == `SEBL_PWORD_LAST) begin
          program_ram_we <= 1'b1;
          program_ram_addr <= program_ram_addr + 10'h001;
          program_ram_data <= {asm_q[23:0], new_byte};
        end
        // Coefficient completes on its odd low byte
        if (in_range(byte_addr_q, `SEBL_A_CFIRST, `SEBL_A_CLAST) && byte_addr_q[0]) begin
          coefficient_ram_we <= 1'b1;
          coefficient_ram_addr <= coefficient_ram_addr + 10'h001;
          coefficient_ram_data <= {asm_q[7:0], new_byte};
        end
        // Offset entries: mod-3 phase, three bytes each
        if (in_range(byte_addr_q, `SEBL_A_OFIRST, `SEBL_A_OLAST)) begin
          if (ofs_ph_q == `SEBL_OFS_LAST) begin
            ofs_ph_q <= 2'h0;
            offset_ram_we <= 1'b1;
            offset_ram_addr <= offset_ram_addr + 6'h01;
            offset_ram_data <= {asm_q[15:0], new_byte};
          end else begin
            ofs_ph_q <= ofs_ph_q + 2'h1;
          end
        end
        // Control data sits on odd bytes after each command byte
        if (in_range(byte_addr_q, `SEBL_A_KFIRST, `SEBL_A_KLAST) && byte_addr_q[0])
          ctl_we <= 1'b1;
        // Reserved bytes 0FFAh, 0FFBh and 0FFFh fall in no range and are dropped
      end
      if (ctl_we)
        ctl_idx_q <= ctl_idx_q + 3'h1;
    end
  end

  // Control registers loaded in order, index counts pairs already taken
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      control_reg_0 <= 8'h00;
      control_reg_1 <= 8'h00;
      control_reg_2 <= 8'h00;
      control_reg_3 <= 8'h00;
      control_reg_4 <= 8'h00;
      control_reg_5 <= 8'h00;
    end else if (ctl_we && ctl_idx_q < `SEBL_CTL_COUNT) begin
      case (ctl_idx_q)
        3'h0: control_reg_0 <= asm_q[7:0];
        3'h1: control_reg_1 <= asm_q[7:0];
        3'h2: control_reg_2 <= asm_q[7:0];
        3'h3: control_reg_3 <= asm_q[7:0];
        3'h4: control_reg_4 <= asm_q[7:0];
        default: control_reg_5 <= asm_q[7:0];
      endcase
    end
  end

endmodule // sebl_loader
